// >>> rtl/initial_reset_sequencer.sv
// Purpose: initial reset latch, cpu start values and pin defaults
// Assumes: pclk 25 MHz, reset pin and low-speed clock sampled on pclk
// Notes: apb slave for stack pointer, extension and power registers
// Functional notes
// - low reset pin holds latch until tick
// - release within 250 ms after pin high
// - program counter loads 0110H on reset
// - interrupt and extension flags cleared
// - interrupts masked until both pointers written
// - rewrite one pointer remasks until other
// - extension write sets extension flag
// - ram and display memory not cleared
// - shared pins revert to port function only while in reset; the ctrl func_sel is kept and returns at release
// - twelve output pins drive high
// - io groups zero to three pulled up
// - converter pins high impedance, no pull-up
// - regulator voltage writes have no effect
// - power mode writes have no effect
//
// Our own choices: the APB slave port and the register addresses.
`include "reset_seq_defines.svh"
`timescale 1ns/1ps
`default_nettype none

module initial_reset_sequencer (
    // clock, reset, enable
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clk_en,
    // external pins
    input wire logic reset_pin_n,
    input wire logic low_speed_oscillator,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // cpu and pin state
    output logic internal_reset,
    output reset_seq_pkg::cpu_start_t cpu_start,
    output reset_seq_pkg::pin_state_t pin_state
);

    // ******************************************
    // low-speed clock edge detection
    // ******************************************
    logic ls_sync1;
    logic ls_sync2;
    logic ls_prev;
    logic [13:0] ls_div;
    logic tick_high;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ls_sync1 <= 1'b0;
            ls_sync2 <= 1'b0;
            ls_prev <= 1'b0;
        end else if (clk_en) begin
            ls_sync1 <= low_speed_oscillator;
            ls_sync2 <= ls_sync1;
            ls_prev <= ls_sync2;
        end
    end

    // divide by 16384: tick is the upper half of the 2 Hz wave
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ls_div <= 14'h0000;
        end else if (clk_en && ls_sync2 && !ls_prev) begin
            ls_div <= ls_div + 14'h0001;
        end
    end

    assign tick_high = ls_div[13];

    // ******************************************
    // reset latch and release sequence
    // ******************************************
    reset_seq_pkg::seq_state_t state;
    reset_seq_pkg::seq_state_t next_state;

    always_comb begin
        next_state = state;
        case (state)
            reset_seq_pkg::st_hold: begin
                if (reset_pin_n) begin
                    next_state = reset_seq_pkg::st_wait_tick;
                end
            end
            reset_seq_pkg::st_wait_tick: begin
                if (!reset_pin_n) begin
                    next_state = reset_seq_pkg::st_hold;
                end else if (tick_high) begin
                    next_state = reset_seq_pkg::st_run;
                end
            end
            reset_seq_pkg::st_run: begin
                if (!reset_pin_n) begin
                    next_state = reset_seq_pkg::st_hold;
                end
            end
            default: begin
                next_state = reset_seq_pkg::st_hold;
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= reset_seq_pkg::st_hold;
        end else if (clk_en) begin
            state <= next_state;
        end
    end

    // latch set while pin low, cleared only by tick
    assign internal_reset = (state != reset_seq_pkg::st_run);

    // ******************************************
    // apb access
    // ******************************************
    logic wr_en;
    logic rd_en;
    logic [7:0] word_stack_pointer;
    logic [7:0] nibble_stack_pointer;
    logic [7:0] extension_reg;
    logic wsp_set;
    logic nsp_set;
    logic [1:0] pwr_ctrl;
    logic ext_flag;
    logic [3:0] func_sel;

    function automatic logic mapped(input logic [11:0] a);
        mapped = (a == `OFS_CTRL) || (a == `OFS_STATUS) || (a == `OFS_WSP) ||
                 (a == `OFS_NSP) || (a == `OFS_EXT) || (a == `OFS_PWR) ||
                 (a == `OFS_PORT);
    endfunction

    assign pready = 1'b1;
    assign pslverr = psel && penable && !mapped(paddr);
    assign wr_en = clk_en && psel && penable && pwrite && mapped(paddr) && !internal_reset;
    // read data captured in setup, so it stands at the access edge
    assign rd_en = clk_en && psel && !penable && !pwrite;

    // ******************************************
    // write strobe decode
    // ******************************************
    logic wr_ctrl;
    logic wr_wsp;
    logic wr_nsp;
    logic wr_ext;
    logic wr_pwr;
    logic wr_port;

    always_comb begin
        wr_ctrl = 1'b0;
        wr_wsp = 1'b0;
        wr_nsp = 1'b0;
        wr_ext = 1'b0;
        wr_pwr = 1'b0;
        wr_port = 1'b0;
        if (wr_en) begin
            if (paddr == `OFS_CTRL) begin
                wr_ctrl = 1'b1;
            end else if (paddr == `OFS_WSP) begin
                wr_wsp = 1'b1;
            end else if (paddr == `OFS_NSP) begin
                wr_nsp = 1'b1;
            end else if (paddr == `OFS_EXT) begin
                wr_ext = 1'b1;
            end else if (paddr == `OFS_PWR) begin
                wr_pwr = 1'b1;
            end else if (paddr == `OFS_PORT) begin
                wr_port = 1'b1;
            end
        end
    end

    // ******************************************
    // cpu registers and interrupt mask
    // ******************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            word_stack_pointer <= 8'h00;
            nibble_stack_pointer <= 8'h00;
            extension_reg <= 8'h00;
            pwr_ctrl <= 2'h0;
            func_sel <= 4'h0;
        end else if (wr_en) begin
            // contents kept over internal reset, like memory
            if (paddr == `OFS_WSP) begin
                word_stack_pointer <= pwdata[7:0];
            end else if (paddr == `OFS_NSP) begin
                nibble_stack_pointer <= pwdata[7:0];
            end else if (paddr == `OFS_EXT) begin
                extension_reg <= pwdata[7:0];
            end else if (paddr == `OFS_PWR) begin
                // stored only; regulator and mode stay fixed
                pwr_ctrl <= pwdata[1:0];
            end else if (paddr == `OFS_CTRL) begin
                func_sel <= pwdata[3:0];
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wsp_set <= 1'b0;
            nsp_set <= 1'b0;
        end else if (clk_en) begin
            if (internal_reset) begin
                wsp_set <= 1'b0;
                nsp_set <= 1'b0;
            end else if (wr_wsp) begin
                wsp_set <= 1'b1;
                if (wsp_set && nsp_set) begin
                    nsp_set <= 1'b0;
                end
            end else if (wr_nsp) begin
                nsp_set <= 1'b1;
                if (wsp_set && nsp_set) begin
                    wsp_set <= 1'b0;
                end
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ext_flag <= 1'b0;
        end else if (clk_en) begin
            if (internal_reset) begin
                ext_flag <= 1'b0;
            end else if (wr_ext) begin
                ext_flag <= 1'b1;
            end else if (wr_ctrl && pwdata[8]) begin
                ext_flag <= 1'b0;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h00000000;
        end else if (rd_en) begin
            if (paddr == `OFS_CTRL) begin
                prdata <= {28'h0000000, func_sel};
            end else if (paddr == `OFS_STATUS) begin
                prdata <= {27'h0000000, ext_flag, nsp_set, wsp_set, cpu_start.int_mask,
                           internal_reset};
            end else if (paddr == `OFS_WSP) begin
                prdata <= {24'h000000, word_stack_pointer};
            end else if (paddr == `OFS_NSP) begin
                prdata <= {24'h000000, nibble_stack_pointer};
            end else if (paddr == `OFS_EXT) begin
                prdata <= {24'h000000, extension_reg};
            end else if (paddr == `OFS_PWR) begin
                prdata <= {30'h00000000, pwr_ctrl};
            end else begin
                prdata <= 32'h00000000;
            end
        end
    end

    // ******************************************
    // cpu start values and pin defaults
    // ******************************************
    assign cpu_start.pc = `START_PC;
    assign cpu_start.int_flag = 1'b0;
    assign cpu_start.ext_flag = ext_flag;
    assign cpu_start.int_mask = !(wsp_set && nsp_set);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_state.out_level <= `OUT_PORT_RESET;
            pin_state.pullup_en <= 20'h0ffff;
            pin_state.dir_in <= 20'hfffff;
            pin_state.func_sel <= 4'h0;
        end else if (clk_en) begin
            if (internal_reset) begin
                pin_state.out_level <= `OUT_PORT_RESET;
                pin_state.pullup_en <= 20'h0ffff;
                pin_state.dir_in <= 20'hfffff;
                pin_state.func_sel <= 4'h0;
            end else begin
                pin_state.func_sel <= func_sel;
                if (wr_port) begin
                    pin_state.out_level <= pwdata[11:0];
                end
            end
        end
    end

endmodule
`default_nettype wire

// >>> rtl/reset_seq_defines.svh
// Purpose: constants for the initial reset sequencer
// Assumes: pclk at 25 MHz, low-speed oscillator at 32.768 kHz
// Notes: byte offsets are register addresses on the apb bus
`ifndef RESET_SEQ_DEFINES_SVH
`define RESET_SEQ_DEFINES_SVH

`define PCLK_HZ 25000000
`define LS_CLK_HZ 32768
`define LS_DIV_RATIO 16384
`define LS_DIV_HALF 8192
`define LS_RELEASE_MAX_MS 250
`define START_PC 16'h0110

`define OFS_CTRL 12'h000
`define OFS_STATUS 12'h004
`define OFS_WSP 12'h008
`define OFS_NSP 12'h00c
`define OFS_EXT 12'h010
`define OFS_PWR 12'h014
`define OFS_PORT 12'h018

`define OUT_PORT_WIDTH 12
`define OUT_PORT_RESET 12'hfff
`define IO_GROUPS 5
`define IO_WIDTH 20

`endif

// >>> rtl/reset_seq_pkg.sv
// Purpose: types for the initial reset sequencer
// Assumes: constants come from reset_seq_defines.svh
// Notes: none
package reset_seq_pkg;

    typedef enum logic [1:0] {
        st_hold = 2'b00,
        st_wait_tick = 2'b01,
        st_run = 2'b10
    } seq_state_t;

    typedef struct packed {
        logic [15:0] pc;
        logic int_flag;
        logic ext_flag;
        logic int_mask;
    } cpu_start_t;

    typedef struct packed {
        logic [11:0] out_level;
        logic [19:0] pullup_en;
        logic [19:0] dir_in;
        logic [3:0] func_sel;
    } pin_state_t;

endpackage

// >>> tb/reset_seq_monitor.sv
// Purpose: checker on top ports
// Assumes: bound in the bench
// Notes: none
`include "reset_seq_defines.svh"
`timescale 1ns/1ps
`default_nettype none
module reset_seq_monitor (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clk_en,
    // pin and bus
    input wire logic reset_pin_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    // outputs
    input wire logic internal_reset,
    input wire reset_seq_pkg::cpu_start_t cpu_start,
    input wire reset_seq_pkg::pin_state_t pin_state
);
    // ****
    // checks
    // ****
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence s_held;
        internal_reset [*3];
    endsequence
    a_pin_holds: assert property (clk_en && !reset_pin_n |-> ##[1:3] internal_reset)
        else $error("pin low, no reset");
    a_pc_start: assert property (cpu_start.pc == `START_PC)
        else $error("bad pc");
    a_flags_clear: assert property (s_held |-> !cpu_start.ext_flag && !cpu_start.int_flag)
        else $error("flags set");
    a_mask_held: assert property (s_held |-> cpu_start.int_mask)
        else $error("unmasked");
    a_out_high: assert property (s_held |-> pin_state.out_level == `OUT_PORT_RESET)
        else $error("outputs low");
    a_pull_up: assert property (s_held |-> pin_state.pullup_en == 20'h0ffff)
        else $error("bad pull-ups");
    a_func_port: assert property (s_held |-> pin_state.func_sel == 4'h0)
        else $error("not port");
    a_ext_sets: assert property (psel && penable && pwrite && paddr == `OFS_EXT
        && !internal_reset && clk_en |=> cpu_start.ext_flag)
        else $error("ext flag clear");
endmodule
`default_nettype wire

// >>> tb/reset_source.sv
// Purpose: reset source and slow clock
// Assumes: slow clock sped up, 122 ns
// Notes: hold times are parameters
`timescale 1ns/1ps
`default_nettype none
module reset_source #(
    parameter int POWER_LOW_NS = 2000100,
    parameter int PULSE_NS = 100000
) (
    // request
    input wire logic kick,
    // pins
    output logic reset_pin_n,
    output logic low_speed_oscillator
);
    // ****
    // pin and clock
    // ****
    initial begin
        reset_pin_n = 1'b0;
        #(POWER_LOW_NS) reset_pin_n = 1'b1;
        @(posedge kick);
        reset_pin_n = 1'b0;
        #(PULSE_NS) reset_pin_n = 1'b1;
    end
    // half-ns offset keeps slow edges off pclk edges
    initial begin
        low_speed_oscillator = 1'b0;
        #0.5;
        forever #61 low_speed_oscillator = ~low_speed_oscillator;
    end
endmodule
`default_nettype wire

// >>> tb/test_initial_reset_sequencer.sv
// Purpose: bench for the reset sequencer
// Assumes: zero-wait apb
// Notes: none
`include "reset_seq_defines.svh"
`timescale 1ns/1ps
`default_nettype none
module test_initial_reset_sequencer;
    // power-up hold plus 8192 slow periods, in pclk cycles, plus margin
    localparam int LIM = 80000;
    logic pclk, presetn, clk_en, psel, penable, pwrite, kick, reset_pin_n, low_speed_oscillator;
    logic pready, pslverr, internal_reset, err;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    reset_seq_pkg::cpu_start_t cpu_start;
    reset_seq_pkg::pin_state_t pin_state;
    int mismatches, tests_run, waited;
    reset_source u_src (.kick, .reset_pin_n, .low_speed_oscillator);
    initial_reset_sequencer u_dut (.pclk, .presetn, .clk_en, .reset_pin_n,
        .low_speed_oscillator, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
        .pslverr, .internal_reset, .cpu_start, .pin_state);
    always #20 pclk = ~pclk;
    // ****
    // tasks
    // ****
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            mismatches++;
            $display("BAD %s exp %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic close_out();
        $display("checks %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        err = pslverr;
        rd = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
        #1;
        if (n >= 20) begin
            mismatches++;
            close_out();
        end
    endtask
    task automatic wait_rst();
        waited = 0;
        while (internal_reset !== 1'b0 && waited < LIM) begin
            @(posedge pclk);
            #1 waited++;
        end
        if (waited >= LIM) begin
            mismatches++;
            close_out();
        end
    endtask
    task automatic pin_defaults();
        chk("pc", 32'(cpu_start.pc), 32'h110);
        chk("flags", 32'({cpu_start.int_flag, cpu_start.ext_flag}), 32'h0);
        chk("mask", 32'(cpu_start.int_mask), 32'h1);
        chk("out", 32'(pin_state.out_level), 32'hfff);
        chk("pull", 32'(pin_state.pullup_en), 32'h0ffff);
        chk("dir", 32'(pin_state.dir_in), 32'hfffff);
        chk("func", 32'(pin_state.func_sel), 32'h0);
    endtask
    // ****
    // sequence
    // ****
    initial begin
        pclk = 1'b0;
        presetn = 1'b0;
        clk_en = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h0;
        pwdata = 32'h0;
        kick = 1'b0;
        mismatches = 0;
        tests_run = 0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b1, `OFS_PORT, 32'h0);
        pin_defaults();
        wait_rst();
        chk("pin", 32'(reset_pin_n), 32'h1);
        pin_defaults();
        apb(1'b0, `OFS_STATUS, 32'h0);
        chk("status", rd, 32'h2);
        for (int i = 0; i < 4; i++) begin
            apb(1'b1, i[0] ? `OFS_NSP : `OFS_WSP, 32'h1f0);
            chk("sp mask", 32'(cpu_start.int_mask), {31'h0, ~i[0]});
        end
        apb(1'b0, `OFS_WSP, 32'h0);
        chk("wsp", rd, 32'hf0);
        apb(1'b1, `OFS_EXT, 32'h5a);
        chk("ext", 32'(cpu_start.ext_flag), 32'h1);
        apb(1'b0, `OFS_EXT, 32'h0);
        chk("ext reg", rd, 32'h5a);
        apb(1'b1, `OFS_CTRL, 32'h105);
        apb(1'b0, `OFS_CTRL, 32'h0);
        chk("ctrl", rd, 32'h5);
        apb(1'b1, `OFS_PWR, 32'h3);
        clk_en <= 1'b0;
        apb(1'b1, `OFS_PORT, 32'h0f0);
        chk("frozen", 32'(pin_state.out_level), 32'hfff);
        clk_en <= 1'b1;
        apb(1'b1, `OFS_PORT, 32'h5a5);
        apb(1'b0, `OFS_PWR, 32'h0);
        chk("pwr", rd, 32'h3);
        chk("state", 32'({cpu_start.ext_flag, pin_state.func_sel, pin_state.out_level}),
            32'h055a5);
        apb(1'b0, 12'h01c, 32'h0);
        chk("slverr", 32'(err), 32'h1);
        chk("rdata", rd, 32'h0);
        kick <= 1'b1;
        repeat (4) @(posedge pclk);
        #1 chk("ireset", 32'(internal_reset), 32'h1);
        pin_defaults();
        wait_rst();
        chk("pin", 32'(reset_pin_n), 32'h1);
        close_out();
    end
endmodule
bind initial_reset_sequencer reset_seq_monitor u_mon (.pclk, .presetn, .clk_en, .reset_pin_n,
    .psel, .penable, .pwrite, .paddr, .internal_reset, .cpu_start, .pin_state);
`default_nettype wire
